// >>> logic/fsi_pkg.sv
package fsi_pkg;

   // ****************************************
   // Register bus
   // ****************************************
   localparam int          AW          = 4;
   localparam int          DW          = 16;
   localparam logic [3:0]  A_STAT      = 4'h0;
   localparam logic [3:0]  A_SEC       = 4'h1;
   localparam logic [3:0]  A_PROT      = 4'h2;
   localparam logic [3:0]  A_OPT       = 4'h3;
   localparam logic [3:0]  A_CMD       = 4'h4;
   localparam logic [3:0]  A_ADDR      = 4'h5;
   localparam logic [3:0]  A_DATA      = 4'h6;
   localparam logic [3:0]  A_KEY0      = 4'h7;
   localparam logic [3:0]  A_IRQ_STAT  = 4'hB;
   localparam logic [3:0]  A_IRQ_MASK  = 4'hC;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int          ST_CMPL     = 7;
   localparam int          ST_ACCERR   = 5;
   localparam int          ST_KLOCK    = 4;
   localparam int          SEC_LSB     = 0;
   localparam int          KEY_EN_LSB  = 6;
   localparam int          IRQ_W       = 4;
   localparam int          IRQ_DONE    = 0;
   localparam int          IRQ_ACCERR  = 1;
   localparam int          IRQ_FAULT   = 2;
   localparam int          IRQ_KEYFAIL = 3;

   // ****************************************
   // Encodings and configuration field
   // ****************************************
   localparam logic [1:0]  SEC_UNSECURE = 2'h2;
   localparam logic [1:0]  KEY_EN_ON    = 2'h2;
   localparam logic [15:0] KEY_ZERO     = 16'h0000;
   localparam logic [15:0] KEY_ONES     = 16'hFFFF;
   localparam logic [7:0]  CMD_PROGRAM  = 8'h06;
   localparam logic [7:0]  CMD_ERASE_ALL = 8'h08;
   localparam logic [7:0]  CMD_ERASE_SEC = 8'h0A;
   localparam logic [7:0]  CMD_VERIFY   = 8'h0C;
   localparam logic [1:0]  OP_PROG      = 2'h0;
   localparam logic [1:0]  OP_ERASE_SEC = 2'h1;
   localparam logic [1:0]  OP_ERASE_ALL = 2'h2;
   localparam logic [23:0] CFG_KEY_ADDR = 24'hFF_FE00;
   localparam logic [23:0] CFG_PROT_ADDR = 24'hFF_FE0C;
   localparam logic [23:0] CFG_SEC_ADDR = 24'hFF_FE0E;
   localparam logic [2:0]  CFG_LAST_IDX = 3'h5;
   localparam logic [2:0]  CFG_HOLD_IDX = 3'h4;
   localparam int          VERIFY_CYCLES = 4;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [3:0][15:0] key;
      logic [7:0]       pprot;
      logic [7:0]       eprot;
      logic [7:0]       opt;
      logic [7:0]       sec;
   } fsi_cfg_t;

   typedef struct packed {
      logic [1:0]  kind;
      logic [23:0] addr;
      logic [15:0] data;
   } fsi_op_t;

   // Fully protected, secured, backdoor disabled
   localparam fsi_cfg_t CFG_DEFAULT = '{key: {4{16'hFFFF}}, pprot: 8'h00, eprot: 8'h00,
                                        opt: 8'hFF, sec: 8'hFF};

   typedef enum logic [4:0] {
      ST_INIT_REQ  = 5'b00001,
      ST_INIT_WAIT = 5'b00010,
      ST_IDLE      = 5'b00100,
      ST_VERIFY    = 5'b01000,
      ST_OP        = 5'b10000
   } fsi_state_t;

endpackage

// >>> logic/fsi_top.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns

// Function
// - Finish running command before granting stop
// - Load security register from configuration byte
// - New security byte acts after reset
// - Verify command compares four 16-bit keys
// - Key match forces unsecured security state
// - All-zeros and all-ones keys never match
// - Flash reads invalid during key verify
// - Wrong key locks verify until reset
// - Verify leaves stored configuration untouched
// - Unsecured part may erase/program security sector
// - Command availability gated by mode, security
// - Reset loads keys, protections, option, security
// - Init errors select secured protected defaults
// - Double fault in init sets both status bits
// - Command complete low through init, then high
// - Hold CPU during part of init
// - Reset aborts a running command at once
// - Special mode erase-all pin unsecures part
module fsi_top
   import fsi_pkg::*;
#(
   parameter int VERIFY_LEN = VERIFY_CYCLES
) (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   // Register port
   input  wire logic [AW-1:0]     addr_i,
   input  wire logic [DW-1:0]     wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DW-1:0]     rdata_o,
   // Configuration field read port
   output logic                   cfg_rd_o,
   output logic      [23:0]       cfg_addr_o,
   input  wire logic [15:0]       cfg_rdata_i,
   input  wire logic              cfg_valid_i,
   input  wire logic              cfg_dbl_i,
   // Array operation port
   output logic                   op_start_o,
   output fsi_op_t                op_o,
   output logic                   op_abort_o,
   input  wire logic              op_done_i,
   // System side
   input  wire logic              special_mode_i,
   input  wire logic              erase_all_pin_i,
   input  wire logic              stop_req_i,
   output logic                   stop_ack_o,
   output logic                   cpu_hold_o,
   output logic                   read_invalid_o,
   output logic                   unsecured_o,
   output logic                   irq_o
);

   // ****************************************
   // Parameter checks
   // ****************************************
   // Verify counter is eight bits wide
   if (VERIFY_LEN < 1 || VERIFY_LEN > 255) begin : g_bad_len
      $error("VERIFY_LEN out of range");
   end
   // Key slots are indexed by two bits, then protection, then option word
   if (CFG_HOLD_IDX != 3'h4 || CFG_LAST_IDX != 3'h5) begin : g_bad_idx
      $error("configuration word indices do not fit the key slots");
   end

   // ****************************************
   // State
   // ****************************************
   fsi_state_t            state_reg, state_next;
   fsi_cfg_t              cfg_reg, cfg_next, cfg_ld;
   logic [2:0]            idx_reg;
   logic                  err_reg;
   logic                  cmpl_reg;
   logic                  accerr_reg;
   logic [1:0]            mg_reg;
   logic                  klock_reg;
   logic                  eall_auto_reg;
   logic [7:0]            cnt_reg;
   logic [23:0]           op_addr_reg;
   logic [15:0]           op_data_reg;
   logic [3:0][15:0]      cand_reg;
   logic [IRQ_W-1:0]      irq_stat_reg;
   logic [IRQ_W-1:0]      irq_mask_reg;
   logic [1:0]            mode_sync_reg;
   logic [1:0]            pin_sync_reg;
   logic                  pin_prev_reg;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mode_sync_reg <= 2'h0;
         pin_sync_reg  <= 2'h0;
         pin_prev_reg  <= 1'b0;
      end else begin
         mode_sync_reg <= {mode_sync_reg[0], special_mode_i};
         pin_sync_reg  <= {pin_sync_reg[0], erase_all_pin_i};
         pin_prev_reg  <= pin_sync_reg[1];
      end
   end

   wire special   = mode_sync_reg[1];
   // Previous level resets to the idle low, so reset gives no false edge
   wire pin_rise  = pin_sync_reg[1] & ~pin_prev_reg;

   // ****************************************
   // Decode
   // ****************************************
   wire [1:0] sec_field  = cfg_reg.sec[SEC_LSB +: 2];
   wire [1:0] key_en     = cfg_reg.sec[KEY_EN_LSB +: 2];
   wire       unsecured  = (sec_field == SEC_UNSECURE);
   wire       idle       = (state_reg == ST_IDLE);
   wire       cmd_wr     = wr_i && (addr_i == A_CMD);
   wire [7:0] code       = wdata_i[7:0];
   wire       is_verify  = (code == CMD_VERIFY);
   wire       is_eall    = (code == CMD_ERASE_ALL);
   wire       is_pe      = (code == CMD_PROGRAM) || (code == CMD_ERASE_SEC);
   wire       verify_ok  = is_verify && (key_en == KEY_EN_ON) && !klock_reg;
   wire       pe_ok      = is_pe && unsecured;
   wire       eall_ok    = is_eall && (unsecured || special);
   wire       cmd_ok     = verify_ok || pe_ok || eall_ok;
   wire       launch     = cmd_wr && idle && cmpl_reg && !stop_ack_o && cmd_ok;
   // Any command write that cannot start is flagged, never queued
   wire       refuse     = cmd_wr && !launch;
   // A register launch in the same cycle wins; that pin edge is dropped
   wire       auto_eall  = pin_rise && idle && cmpl_reg && special && !unsecured && !launch;
   wire       init_fin   = (state_reg == ST_INIT_WAIT) && cfg_valid_i && (idx_reg == CFG_LAST_IDX);
   wire       verify_end = (state_reg == ST_VERIFY) && (cnt_reg == 8'(VERIFY_LEN - 1));
   wire       op_end     = (state_reg == ST_OP) && op_done_i;
   wire       cmd_end    = verify_end || op_end;
   wire       init_fault = (state_reg == ST_INIT_WAIT) && cfg_valid_i && cfg_dbl_i;

   // Per-key compare; reserved values never count as a match
   logic [3:0] key_good;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_key
         assign key_good[gi] = (cand_reg[gi] == cfg_reg.key[gi])
                            && (cand_reg[gi] != KEY_ZERO) && (cand_reg[gi] != KEY_ONES);
      end
   endgenerate
   wire key_match = &key_good;

   // Address of the configuration word being fetched
   wire [23:0] key_word_addr = CFG_KEY_ADDR + {21'h0, idx_reg[1:0], 1'b0};
   wire [23:0] cfg_word_addr = (idx_reg < CFG_HOLD_IDX) ? key_word_addr
                             : (idx_reg == CFG_HOLD_IDX) ? CFG_PROT_ADDR : CFG_SEC_ADDR;

   // ****************************************
   // Configuration load
   // ****************************************
   always_comb begin
      cfg_ld = cfg_reg;
      if ((state_reg == ST_INIT_WAIT) && cfg_valid_i) begin
         if (idx_reg < CFG_HOLD_IDX) begin
            cfg_ld.key[idx_reg[1:0]] = cfg_rdata_i;
         end else if (idx_reg == CFG_HOLD_IDX) begin
            cfg_ld.pprot = cfg_rdata_i[15:8];
            cfg_ld.eprot = cfg_rdata_i[7:0];
         end else begin
            cfg_ld.opt = cfg_rdata_i[15:8];
            cfg_ld.sec = cfg_rdata_i[7:0];
         end
      end
      cfg_next = cfg_ld;
      if (init_fin && (err_reg || cfg_dbl_i)) begin
         cfg_next = CFG_DEFAULT;
      end
      // Only the live field moves; the stored byte and keys stay as they are
      if (verify_end && key_match) begin
         cfg_next.sec[SEC_LSB +: 2] = SEC_UNSECURE;
      end
      if (op_end && eall_auto_reg) begin
         cfg_next.sec[SEC_LSB +: 2] = SEC_UNSECURE;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_INIT_REQ:  state_next = ST_INIT_WAIT;
         ST_INIT_WAIT: begin
            if (cfg_valid_i) begin
               state_next = (idx_reg == CFG_LAST_IDX) ? ST_IDLE : ST_INIT_REQ;
            end
         end
         ST_IDLE: begin
            if (launch && is_verify) begin
               state_next = ST_VERIFY;
            end else if (launch || auto_eall) begin
               state_next = ST_OP;
            end
         end
         ST_VERIFY:    state_next = verify_end ? ST_IDLE : ST_VERIFY;
         ST_OP:        state_next = op_done_i ? ST_IDLE : ST_OP;
         default:      state_next = ST_INIT_REQ;
      endcase
   end

   // Reset drops any running operation, so the security byte
   // is only ever read back from the array here
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_reg <= ST_INIT_REQ;
         cfg_reg   <= CFG_DEFAULT;
         idx_reg   <= 3'h0;
         err_reg   <= 1'b0;
         cnt_reg   <= 8'h00;
         klock_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cfg_reg   <= cfg_next;
         if (state_reg == ST_INIT_WAIT && cfg_valid_i) begin
            idx_reg <= idx_reg + 3'h1;
            err_reg <= err_reg | cfg_dbl_i;
         end
         cnt_reg <= (state_reg == ST_VERIFY) ? cnt_reg + 8'h01 : 8'h00;
         // Held until reset; nothing else reopens the verify command
         if (verify_end && !key_match) begin
            klock_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Flags and operation port
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cmpl_reg      <= 1'b0;
         accerr_reg    <= 1'b0;
         mg_reg        <= 2'h0;
         eall_auto_reg <= 1'b0;
         op_addr_reg   <= 24'h0;
         op_data_reg   <= 16'h0;
         op_start_o    <= 1'b0;
         op_o          <= '0;
         op_abort_o    <= 1'b1;
         cfg_rd_o      <= 1'b0;
         cfg_addr_o    <= 24'h0;
         cpu_hold_o    <= 1'b1;
         read_invalid_o <= 1'b0;
         stop_ack_o    <= 1'b0;
         unsecured_o   <= 1'b0;
      end else begin
         // Abort also covers the first edge after release
         op_abort_o <= 1'b0;
         if (init_fin || cmd_end) begin
            cmpl_reg <= 1'b1;
         end else if (launch || auto_eall) begin
            cmpl_reg <= 1'b0;
         end
         if (refuse) begin
            accerr_reg <= 1'b1;
         end else if (launch) begin
            accerr_reg <= 1'b0;
         end
         if (init_fault) begin
            mg_reg <= 2'h3;
         end else if (launch) begin
            mg_reg <= 2'h0;
         end
         if (launch || auto_eall) begin
            eall_auto_reg <= auto_eall;
         end
         if (wr_i && addr_i == A_ADDR) begin
            op_addr_reg <= {8'hFF, wdata_i};
         end
         if (wr_i && addr_i == A_DATA) begin
            op_data_reg <= wdata_i;
         end
         op_start_o <= (launch && !is_verify) || auto_eall;
         if (launch || auto_eall) begin
            op_o.kind <= (auto_eall || is_eall) ? OP_ERASE_ALL
                       : (code == CMD_PROGRAM) ? OP_PROG : OP_ERASE_SEC;
            op_o.addr <= op_addr_reg;
            op_o.data <= op_data_reg;
         end
         cfg_rd_o   <= (state_reg == ST_INIT_REQ);
         cfg_addr_o <= cfg_word_addr;
         if (state_reg == ST_INIT_WAIT && cfg_valid_i && idx_reg == 3'(CFG_HOLD_IDX - 1)) begin
            cpu_hold_o <= 1'b0;
         end
         // Raised on the launch edge so no array read slips in
         read_invalid_o <= (state_next == ST_VERIFY);
         // Grant only with no command running
         stop_ack_o  <= stop_req_i && cmpl_reg && idle && !launch && !auto_eall;
         unsecured_o <= (cfg_next.sec[SEC_LSB +: 2] == SEC_UNSECURE);
      end
   end

   // ****************************************
   // Software registers and interrupt
   // ****************************************
   wire [IRQ_W-1:0] irq_evt;
   assign irq_evt[IRQ_DONE]    = init_fin || cmd_end;
   assign irq_evt[IRQ_ACCERR]  = refuse;
   assign irq_evt[IRQ_FAULT]   = init_fault;
   assign irq_evt[IRQ_KEYFAIL] = verify_end && !key_match;
   wire [IRQ_W-1:0] irq_clr = (wr_i && addr_i == A_IRQ_STAT) ? wdata_i[IRQ_W-1:0] : '0;

   wire [7:0] stat_byte = {cmpl_reg, 1'b0, accerr_reg, klock_reg, 2'h0, mg_reg};
   wire [3:0] key_sel   = addr_i - A_KEY0;
   wire [DW-1:0] rd_mux =
        (addr_i == A_STAT)     ? {8'h00, stat_byte}
      : (addr_i == A_SEC)      ? {8'h00, cfg_reg.sec}
      : (addr_i == A_PROT)     ? {cfg_reg.pprot, cfg_reg.eprot}
      : (addr_i == A_OPT)      ? {8'h00, cfg_reg.opt}
      : (addr_i == A_ADDR)     ? op_addr_reg[15:0]
      : (addr_i == A_DATA)     ? op_data_reg
      : (addr_i == A_IRQ_STAT) ? {{(DW-IRQ_W){1'b0}}, irq_stat_reg}
      : (addr_i == A_IRQ_MASK) ? {{(DW-IRQ_W){1'b0}}, irq_mask_reg}
      : 16'h0000;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cand_reg     <= '0;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         rdata_o      <= 16'h0000;
         irq_o        <= 1'b0;
      end else begin
         if (wr_i && addr_i >= A_KEY0 && addr_i < A_IRQ_STAT) begin
            cand_reg[key_sel[1:0]] <= wdata_i;
         end
         // A new event outweighs a clear in the same cycle
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
         if (wr_i && addr_i == A_IRQ_MASK) begin
            irq_mask_reg <= wdata_i[IRQ_W-1:0];
         end
         rdata_o <= rd_i ? rd_mux : 16'h0000;
         irq_o   <= |(((irq_stat_reg & ~irq_clr) | irq_evt) & irq_mask_reg);
      end
   end

endmodule

// >>> tb/fsi_top_assertions.sv
`timescale 1ns/1ns
module fsi_top_assertions
   import fsi_pkg::*;
#(
   parameter int VERIFY_LEN = VERIFY_CYCLES
) (
   // Clock and reset
   input  wire logic          mclk_i,
   input  wire logic          srst_i,
   // Register port
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic          wr_i,
   // Configuration and array ports
   input  wire logic          cfg_rd_o,
   input  wire logic [23:0]   cfg_addr_o,
   input  wire logic          cfg_valid_i,
   input  wire logic          cfg_dbl_i,
   input  wire logic          op_start_o,
   input  wire fsi_op_t       op_o,
   input  wire logic          op_abort_o,
   input  wire logic          op_done_i,
   // System side
   input  wire logic          stop_req_i,
   input  wire logic          stop_ack_o,
   input  wire logic          cpu_hold_o,
   input  wire logic          read_invalid_o,
   input  wire logic          unsecured_o
);
   logic busy_reg;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   // Tracks an array operation between launch and completion
   always_ff @(posedge mclk_i) begin
      if (srst_i || op_done_i) begin
         busy_reg <= 1'b0;
      end else if (op_start_o) begin
         busy_reg <= 1'b1;
      end
   end

   AST_ABORT: assert property ($fell(srst_i) |-> op_abort_o && cpu_hold_o && !unsecured_o && !op_start_o)
      else $error("outputs not in reset state after release");
   AST_CFG_FIRST: assert property ($fell(srst_i) |-> ##[1:3] (cfg_rd_o && cfg_addr_o == CFG_KEY_ADDR))
      else $error("first config read missing");
   AST_CFG_NEXT: assert property (cfg_valid_i && !cfg_dbl_i && cfg_addr_o != CFG_SEC_ADDR |-> ##[1:2] cfg_rd_o)
      else $error("config sequence stalled");
   AST_HOLD_END: assert property ($fell(cpu_hold_o) |-> cfg_addr_o >= 24'hFF_FE06)
      else $error("cpu hold released before keys loaded");
   AST_VERIFY_SRC: assert property ($rose(read_invalid_o) |->
      $past(wr_i) && $past(addr_i) == A_CMD && $past(wdata_i[7:0]) == CMD_VERIFY)
      else $error("read invalid without verify launch");
   AST_VERIFY_END: assert property ($rose(read_invalid_o) |-> ##[1:300] !read_invalid_o)
      else $error("verify never ended");
   AST_STOP: assert property ((busy_reg || op_start_o) |-> !stop_ack_o)
      else $error("stop granted while array busy");
   AST_STOP_REQ: assert property ($rose(stop_ack_o) |-> $past(stop_req_i))
      else $error("stop granted without request");
   AST_LAUNCH: assert property (op_start_o |-> ($past(wr_i) && $past(addr_i) == A_CMD
      && $past(wdata_i[7:0]) != CMD_VERIFY) || op_o.kind == OP_ERASE_ALL)
      else $error("array op without command");
   AST_UNSEC: assert property ($rose(unsecured_o) |-> $past(read_invalid_o) || $past(read_invalid_o, 2)
      || $past(op_done_i) || $past(op_done_i, 2))
      else $error("unsecured without verify or erase all");
endmodule

bind fsi_top fsi_top_assertions #(.VERIFY_LEN(VERIFY_LEN)) chk_i (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i,
   .cfg_rd_o, .cfg_addr_o, .cfg_valid_i, .cfg_dbl_i, .op_start_o, .op_o, .op_abort_o, .op_done_i,
   .stop_req_i, .stop_ack_o, .cpu_hold_o, .read_invalid_o, .unsecured_o);

// >>> tb/fsi_flash_model.sv
`timescale 1ns/1ns
module fsi_flash_model
   import fsi_pkg::*;
#(
   parameter logic [63:0] KEYS   = 64'h1234_5678_9ABC_DEF0,
   parameter int          OP_LEN = 12
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // Configuration read
   input  wire logic        cfg_rd_i,
   input  wire logic [23:0] cfg_addr_i,
   output logic      [15:0] cfg_rdata_o,
   output logic             cfg_valid_o,
   output logic             cfg_dbl_o,
   // Array operations
   input  wire logic        op_start_i,
   input  wire logic        op_abort_i,
   output logic             op_done_o,
   // Fault injection
   input  wire logic        alt_key_i,
   input  wire logic        dbl_req_i
);
   logic [15:0] word_reg;
   logic [1:0]  wait_reg;
   logic        pend_reg;
   logic        dbl_reg;
   logic [7:0]  cnt_reg;
   wire  [15:0] word_sel;

   // Stored field: keys, protections, option and security byte
   assign word_sel = (cfg_addr_i == CFG_PROT_ADDR) ? 16'h3C5A :
                     (cfg_addr_i == CFG_SEC_ADDR) ? 16'hA580 :
                     (cfg_addr_i[2:1] == 2'h3 && alt_key_i) ? KEY_ONES :
                     KEYS[63 - 16 * int'(cfg_addr_i[2:1]) -: 16];
   // Bus is not held once valid drops
   assign cfg_rdata_o = cfg_valid_o ? word_reg : ~word_reg;
   assign cfg_dbl_o   = cfg_valid_o & dbl_reg;

   // Latency follows address so both quick and slow answers occur
   always_ff @(posedge mclk_i) begin
      cfg_valid_o <= 1'b0;
      if (srst_i) begin
         pend_reg <= 1'b0;
      end else if (cfg_rd_i) begin
         pend_reg <= 1'b1;
         wait_reg <= cfg_addr_i[2:1];
         word_reg <= word_sel;
         dbl_reg  <= dbl_req_i && cfg_addr_i == 24'hFF_FE02;
      end else if (pend_reg && wait_reg == 2'h0) begin
         pend_reg    <= 1'b0;
         cfg_valid_o <= 1'b1;
      end else if (pend_reg) begin
         wait_reg <= wait_reg - 2'h1;
      end
   end

   // Array keeps running through reset unless aborted
   always_ff @(posedge mclk_i) begin
      op_done_o <= cnt_reg == 8'h01;
      if (op_abort_i) begin
         cnt_reg <= 8'h00;
      end else if (op_start_i) begin
         cnt_reg <= 8'(OP_LEN);
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
   import fsi_pkg::*;
   localparam logic [63:0] KEYS = 64'h1234_5678_9ABC_DEF0;
   logic          mclk_i = 1'b0;
   logic          srst_i = 1'b1;
   logic [3:0]    addr_i = 4'h0;
   logic [15:0]   wdata_i = 16'h0000;
   logic          wr_i = 1'b0;
   logic          rd_i = 1'b0;
   logic          special_mode_i = 1'b0;
   logic          erase_all_pin_i = 1'b0;
   logic          stop_req_i = 1'b0;
   logic          alt_key = 1'b0;
   logic          dbl_req = 1'b0;
   logic [15:0]   rdata_o, cfg_rdata_i, d;
   logic [23:0]   cfg_addr_o;
   logic          cfg_rd_o, cfg_valid_i, cfg_dbl_i, op_start_o, op_abort_o, op_done_i;
   logic          stop_ack_o, cpu_hold_o, read_invalid_o, unsecured_o, irq_o;
   fsi_op_t       op_o;
   int            fail_count = 0;
   int            samples_checked = 0;

   fsi_top #(.VERIFY_LEN(4)) uut (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cfg_rd_o,
      .cfg_addr_o, .cfg_rdata_i, .cfg_valid_i, .cfg_dbl_i, .op_start_o, .op_o, .op_abort_o, .op_done_i,
      .special_mode_i, .erase_all_pin_i, .stop_req_i, .stop_ack_o, .cpu_hold_o, .read_invalid_o,
      .unsecured_o, .irq_o);
   fsi_flash_model #(.KEYS(KEYS)) flash (.mclk_i, .srst_i, .cfg_rd_i(cfg_rd_o), .cfg_addr_i(cfg_addr_o),
      .cfg_rdata_o(cfg_rdata_i), .cfg_valid_o(cfg_valid_i), .cfg_dbl_o(cfg_dbl_i), .op_start_i(op_start_o),
      .op_abort_i(op_abort_o), .op_done_o(op_done_i), .alt_key_i(alt_key), .dbl_req_i(dbl_req));

   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   task automatic results;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic cmpv(input logic [23:0] g, input logic [23:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic cmpf(input logic g, input logic e);
      cmpv({23'h0, g}, {23'h0, e});
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      @(negedge mclk_i);
      v = rdata_o;
   endtask

   task automatic chk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      cmpv({8'h0, v}, {8'h0, e});
   endtask

   // Polls status so no wait is left open
   task automatic wait_cmpl;
      logic [15:0] v;
      for (int i = 0; i < 200; i++) begin
         rd(A_STAT, v);
         if (v[ST_CMPL] === 1'b1) begin
            return;
         end
      end
      fail_count++;
      results;
   endtask

   task automatic do_reset(input logic alt, input logic dbl);
      @(posedge mclk_i);
      srst_i  <= 1'b1;
      alt_key <= alt;
      dbl_req <= dbl;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(negedge mclk_i);
      cmpf(op_abort_o, 1'b1);
      cmpf(cpu_hold_o, 1'b1);
      wait_cmpl;
      cmpf(cpu_hold_o, 1'b0);
   endtask

   task automatic verify(input logic [63:0] k, input logic inv);
      for (int i = 0; i < 4; i++) begin
         wr(A_KEY0 + 4'(i), k[63 - 16 * i -: 16]);
      end
      wr(A_CMD, {8'h00, CMD_VERIFY});
      @(negedge mclk_i);
      cmpf(read_invalid_o, inv);
      wait_cmpl;
   endtask

   initial begin
      repeat (50000) @(posedge mclk_i);
      fail_count++;
      results;
   end

   initial begin
      do_reset(1'b0, 1'b0);
      chk(A_STAT, 16'h0080);
      chk(A_SEC, 16'h0080);
      chk(A_PROT, 16'h3C5A);
      chk(A_OPT, 16'h00A5);
      chk(A_IRQ_STAT, 16'h0001);
      cmpf(irq_o, 1'b0);
      wr(A_IRQ_MASK, 16'h0001);
      chk(A_IRQ_MASK, 16'h0001);
      cmpf(irq_o, 1'b1);
      wr(A_IRQ_STAT, 16'h0001);
      chk(A_IRQ_STAT, 16'h0000);
      cmpf(irq_o, 1'b0);
      wr(A_ADDR, 16'h1000);
      wr(A_DATA, 16'hBEEF);
      wr(A_CMD, {8'h00, CMD_PROGRAM});
      chk(A_STAT, 16'h00A0);
      verify(KEYS, 1'b1);
      cmpf(unsecured_o, 1'b1);
      chk(A_SEC, 16'h0082);
      chk(A_PROT, 16'h3C5A);
      wr(A_CMD, {8'h00, CMD_PROGRAM});
      @(negedge mclk_i);
      cmpf(op_start_o, 1'b1);
      cmpv(op_o.addr, 24'hFF_1000);
      cmpv({8'h0, op_o.data}, 24'h00_BEEF);
      @(posedge mclk_i);
      stop_req_i <= 1'b1;
      repeat (5) @(negedge mclk_i);
      cmpf(stop_ack_o, 1'b0);
      wait_cmpl;
      @(negedge mclk_i);
      cmpf(stop_ack_o, 1'b1);
      @(posedge mclk_i);
      stop_req_i <= 1'b0;
      chk(A_SEC, 16'h0082);
      wr(A_ADDR, 16'hFE00);
      wr(A_CMD, {8'h00, CMD_ERASE_SEC});
      @(negedge mclk_i);
      cmpv({22'h0, op_o.kind}, {22'h0, OP_ERASE_SEC});
      do_reset(1'b0, 1'b0);
      cmpf(unsecured_o, 1'b0);
      chk(A_SEC, 16'h0080);
      verify({KEYS[63:16], 16'h0001}, 1'b1);
      chk(A_STAT, 16'h0090);
      rd(A_IRQ_STAT, d);
      cmpf(d[IRQ_KEYFAIL], 1'b1);
      wr(A_CMD, {8'h00, CMD_VERIFY});
      chk(A_STAT, 16'h00B0);
      cmpf(unsecured_o, 1'b0);
      do_reset(1'b1, 1'b0);
      verify({KEYS[63:16], KEY_ONES}, 1'b1);
      cmpf(unsecured_o, 1'b0);
      chk(A_STAT, 16'h0090);
      do_reset(1'b0, 1'b1);
      chk(A_STAT, 16'h0083);
      chk(A_SEC, 16'h00FF);
      chk(A_PROT, 16'h0000);
      chk(A_OPT, 16'h00FF);
      do_reset(1'b0, 1'b0);
      wr(A_CMD, {8'h00, CMD_ERASE_ALL});
      chk(A_STAT, 16'h00A0);
      @(posedge mclk_i);
      special_mode_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      erase_all_pin_i <= 1'b1;
      for (int n = 0; n < 20 && op_start_o !== 1'b1; n++) begin
         @(negedge mclk_i);
      end
      cmpf(op_start_o, 1'b1);
      cmpv({22'h0, op_o.kind}, {22'h0, OP_ERASE_ALL});
      wait_cmpl;
      @(negedge mclk_i);
      cmpf(unsecured_o, 1'b1);
      results;
   end
endmodule
